// ### design/sfh_pkg.sv
package sfh_pkg;

    // Clock rate
    localparam int CLK_MHZ = 200;

    // Maximum on time spans 6 us at least peak to 18 us at most peak
    localparam int TON_MIN_NS = 6000;
    localparam int TON_MAX_NS = 18000;
    localparam int TON_MIN_CYC = TON_MIN_NS * CLK_MHZ / 1000;
    localparam int TON_MAX_CYC = TON_MAX_NS * CLK_MHZ / 1000;
    localparam int TON_W = 12;

    // Peak target code from the control law, full scale gives longest on time
    localparam int PEAK_CODE_W = 8;
    localparam int PEAK_CODE_FULL = 255;

    // Diagnostic pulse on the peak programming pin after a thermal trip
    localparam int DIAG_PULSE_NS = 1000;
    localparam int DIAG_PULSE_CYC = DIAG_PULSE_NS * CLK_MHZ / 1000;
    localparam int DIAG_W = 8;

    // Cycle counts for confirmation and for the reduced-peak restart
    localparam logic [1:0] CONSEC_FAULT_CYCLES = 2'h3;
    localparam logic [1:0] SOFT_START_CYCLES = 2'h3;

    // Analog trip points, held here for reference; comparators sit outside
    localparam int VS_OV_MV = 4600;
    localparam int VS_UV_UA = 75;
    localparam int VS_EN_UA = 210;
    localparam int TEMP_TRIP_C = 150;
    localparam int TEMP_HYST_C = 50;
    localparam int CLAMP_OC_UA = 5000;

    // Bit positions of the synchronised comparator vector
    localparam int PIN_VDD_1V = 0;
    localparam int PIN_VDD_ON = 1;
    localparam int PIN_VDD_OFF = 2;
    localparam int PIN_VDD_RESTART = 3;
    localparam int PIN_VS_OV = 4;
    localparam int PIN_VS_LOW = 5;
    localparam int PIN_VS_EN = 6;
    localparam int PIN_TEMP_TRIP = 7;
    localparam int PIN_TEMP_WARM = 8;
    localparam int PIN_PEAK = 9;
    localparam int PIN_OCP1 = 10;
    localparam int PIN_OCP2 = 11;
    localparam int PIN_CLAMP = 12;
    localparam int PIN_W = 13;

    // Fault cause bits, one per cause, several can be set together
    localparam int CAUSE_OV = 0;
    localparam int CAUSE_UV = 1;
    localparam int CAUSE_THERM = 2;
    localparam int CAUSE_OCP1 = 3;
    localparam int CAUSE_OCP2 = 4;
    localparam int CAUSE_TON = 5;
    localparam int CAUSE_CLAMP = 6;
    localparam int CAUSE_W = 7;

    // Supply sequencing states
    typedef enum logic [2:0] {
        ST_CHARGE,
        ST_SOFT,
        ST_RUN,
        ST_FAULT,
        ST_STANDBY
    } sfh_state_type;

endpackage

// ### design/sfh_count_if.sv
`timescale 1ns/1ps
// Link between the sequencer and one consecutive-cycle fault counter
interface sfh_count_if;
    logic cycle_end; // Pulse at each turn-off at the peak or on-time limit
    logic sensed;    // Condition seen in the cycle now ending
    logic restart;   // Pulse at each restart
    logic tripped;   // Count has reached the confirmation figure

    modport ctrl (output cycle_end, output sensed, output restart, input tripped);
    modport counter (input cycle_end, input sensed, input restart, output tripped);
endinterface

// ### design/sfh_pin_sync.sv
`timescale 1ns/1ps
module sfh_pin_sync #(
    parameter int W = 1
) (
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // Asynchronous comparator levels
    input wire logic [W-1:0] pin_in,
    // Settled levels
    output logic [W-1:0] level_out
);

    // Three stages plus the accepted level
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] level;
    } sfh_sync_state_type;

    sfh_sync_state_type s_q;
    sfh_sync_state_type s_d;

    // Take a change only once the second and third stages agree
    always_comb begin
        s_d = s_q;
        s_d.s1 = pin_in;
        s_d.s2 = s_q.s1;
        s_d.s3 = s_q.s2;
        for (int i = 0; i < W; i++) begin
            if (s_q.s2[i] == s_q.s3[i]) begin
                s_d.level[i] = s_q.s3[i];
            end
        end
    end

    // State register
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign level_out = s_q.level;

endmodule // sfh_pin_sync

// ### design/sfh_consec_counter.sv
`timescale 1ns/1ps
module sfh_consec_counter (
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // Sequencer link
    sfh_count_if.counter cnt
);

    // Saturating count and its decoded trip flag
    typedef struct packed {
        logic [1:0] count;
        logic tripped;
    } sfh_count_state_type;

    sfh_count_state_type s_q;
    sfh_count_state_type s_d;

    // Count runs of sensed cycles, any clean cycle starts over
    always_comb begin
        s_d = s_q;
        if (cnt.restart) begin
            s_d.count = '0;
        end else if (cnt.cycle_end) begin
            if (!cnt.sensed) begin
                s_d.count = '0;
            end else if (s_q.count != sfh_pkg::CONSEC_FAULT_CYCLES) begin
                s_d.count = s_q.count + 2'h1;
            end
        end
        // Tripped stays until a restart or a clean cycle clears the count
        s_d.tripped = (s_d.count == sfh_pkg::CONSEC_FAULT_CYCLES);
    end

    // State register
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign cnt.tripped = s_q.tripped;

endmodule // sfh_consec_counter

// ### design/sfh_fault_hiccup.sv
`timescale 1ns/1ps
module sfh_fault_hiccup (
    // Clock and reset
    input wire logic CLK,
    input wire logic RESET_N,
    // Supply comparators
    input wire logic VDD_BELOW_1V,
    input wire logic VDD_ABOVE_TURN_ON,
    input wire logic VDD_BELOW_TURN_OFF,
    input wire logic VDD_BELOW_RESTART,
    // Winding sense comparators
    input wire logic VS_SAMPLE_OVER,
    input wire logic VS_CURRENT_LOW,
    input wire logic VS_CURRENT_ENABLE,
    // Die temperature comparators
    input wire logic TEMP_ABOVE_TRIP,
    input wire logic TEMP_ABOVE_RELEASE,
    // Drain current comparators
    input wire logic DRAIN_ABOVE_PEAK,
    input wire logic DRAIN_ABOVE_OCP1,
    input wire logic DRAIN_ABOVE_OCP2,
    // Supply clamp comparator
    input wire logic CLAMP_OVER_CURRENT,
    // Control law, same clock
    input wire logic SWITCH_REQUEST,
    input wire logic [sfh_pkg::PEAK_CODE_W-1:0] PEAK_CODE,
    input wire logic OUTPUT_IN_REGULATION,
    // Power stage controls
    output logic GATE_ON,
    output logic VS_CLAMP_ON,
    output logic VS_SAMPLE_STROBE,
    output logic REDUCED_PEAK,
    output logic STARTUP_CC_MODE,
    // Supply controls
    output logic HV_SOURCE_ON,
    output logic HV_REDUCED_CHARGE,
    output logic LOGIC_ACTIVE,
    output logic FAULT_CURRENT_MODE,
    // Diagnostics
    output logic IPK_DIAG_PULSE,
    output logic [sfh_pkg::CAUSE_W-1:0] FAULT_CAUSE
);

    // Whole state of the sequencer
    typedef struct packed {
        sfh_pkg::sfh_state_type state;
        logic gate;        // Power switch on
        logic sample;      // Sense current sampled this cycle
        logic ocp1_seen;   // First over-current seen in this on time
        logic therm;       // Thermal fault with hysteresis
        logic line_ok;     // Line current has reached the enable level
        logic in_reg;      // Output has reached regulation
        logic [1:0] soft_cnt;
        logic [sfh_pkg::TON_W-1:0] on_cnt;
        logic [sfh_pkg::DIAG_W-1:0] diag_cnt;
        logic [sfh_pkg::CAUSE_W-1:0] cause;
    } sfh_ctrl_state_type;

    // Reset starts charging the supply from the high-voltage source
    localparam sfh_ctrl_state_type RESET_STATE = '{state: sfh_pkg::ST_CHARGE, default: '0};

    // Derived cycle counts
    localparam logic [sfh_pkg::TON_W-1:0] TON_MIN = sfh_pkg::TON_W'(sfh_pkg::TON_MIN_CYC);
    localparam int TON_SPAN = sfh_pkg::TON_MAX_CYC - sfh_pkg::TON_MIN_CYC;
    localparam int PROD_W = 20;
    localparam logic [PROD_W-1:0] TON_SPAN_P = PROD_W'(TON_SPAN);
    localparam logic [PROD_W-1:0] CODE_FULL_P = PROD_W'(sfh_pkg::PEAK_CODE_FULL);
    localparam logic [sfh_pkg::DIAG_W-1:0] DIAG_LEN = sfh_pkg::DIAG_W'(sfh_pkg::DIAG_PULSE_CYC);

    // Last reduced-peak cycle index
    localparam logic [1:0] SOFT_LAST = sfh_pkg::SOFT_START_CYCLES;

    // Registered state and its next value
    sfh_ctrl_state_type s_q;
    sfh_ctrl_state_type s_d;

    // Settled comparator levels
    logic [sfh_pkg::PIN_W-1:0] pins_raw;
    logic [sfh_pkg::PIN_W-1:0] pins;

    // Per-cycle signals towards the counters
    logic cycle_end;
    logic restart;
    logic uv_sensed;
    logic ocp_sensed;
    logic ton_sensed;

    // On-time limit for the present peak target
    logic [PROD_W-1:0] ton_prod;
    logic [sfh_pkg::TON_W-1:0] ton_limit;

    // Counter links
    sfh_count_if uv_if ();
    sfh_count_if ocp_if ();
    sfh_count_if ton_if ();

    // Gather comparator pins for one synchroniser
    assign pins_raw[sfh_pkg::PIN_VDD_1V] = VDD_BELOW_1V;
    assign pins_raw[sfh_pkg::PIN_VDD_ON] = VDD_ABOVE_TURN_ON;
    assign pins_raw[sfh_pkg::PIN_VDD_OFF] = VDD_BELOW_TURN_OFF;
    assign pins_raw[sfh_pkg::PIN_VDD_RESTART] = VDD_BELOW_RESTART;
    assign pins_raw[sfh_pkg::PIN_VS_OV] = VS_SAMPLE_OVER;
    assign pins_raw[sfh_pkg::PIN_VS_LOW] = VS_CURRENT_LOW;
    assign pins_raw[sfh_pkg::PIN_VS_EN] = VS_CURRENT_ENABLE;
    assign pins_raw[sfh_pkg::PIN_TEMP_TRIP] = TEMP_ABOVE_TRIP;
    assign pins_raw[sfh_pkg::PIN_TEMP_WARM] = TEMP_ABOVE_RELEASE;
    assign pins_raw[sfh_pkg::PIN_PEAK] = DRAIN_ABOVE_PEAK;
    assign pins_raw[sfh_pkg::PIN_OCP1] = DRAIN_ABOVE_OCP1;
    assign pins_raw[sfh_pkg::PIN_OCP2] = DRAIN_ABOVE_OCP2;
    assign pins_raw[sfh_pkg::PIN_CLAMP] = CLAMP_OVER_CURRENT;

    // Comparators are asynchronous; the peak compare thus lands four cycles late
    sfh_pin_sync #(
        .W(sfh_pkg::PIN_W)
    ) u_sync (
        .clk(CLK),
        .reset_n(RESET_N),
        .pin_in(pins_raw),
        .level_out(pins)
    );

    // Consecutive-cycle confirmation for under-voltage
    sfh_consec_counter u_uv_cnt (
        .clk(CLK),
        .reset_n(RESET_N),
        .cnt(uv_if.counter)
    );

    // Consecutive-cycle confirmation for the first over-current level
    sfh_consec_counter u_ocp_cnt (
        .clk(CLK),
        .reset_n(RESET_N),
        .cnt(ocp_if.counter)
    );

    // Consecutive-cycle confirmation for on-time expiry
    sfh_consec_counter u_ton_cnt (
        .clk(CLK),
        .reset_n(RESET_N),
        .cnt(ton_if.counter)
    );

    // Drive the counter links
    assign uv_if.cycle_end = cycle_end;
    assign uv_if.sensed = uv_sensed;
    assign uv_if.restart = restart;
    assign ocp_if.cycle_end = cycle_end;
    assign ocp_if.sensed = ocp_sensed;
    assign ocp_if.restart = restart;
    assign ton_if.cycle_end = cycle_end;
    assign ton_if.sensed = ton_sensed;
    assign ton_if.restart = restart;

    // On-time limit scales linearly with the peak target
    always_comb begin
        // Product stays inside its width even for a full-scale code
        ton_prod = PROD_W'(PEAK_CODE) * TON_SPAN_P;
        ton_limit = TON_MIN + sfh_pkg::TON_W'(ton_prod / CODE_FULL_P);
    end

    // Next-state logic
    always_comb begin
        s_d = s_q;
        s_d.sample = 1'b0;
        cycle_end = 1'b0;
        restart = 1'b0;
        uv_sensed = 1'b0;
        ocp_sensed = 1'b0;
        ton_sensed = 1'b0;

        // Diagnostic pulse runs down
        if (s_q.diag_cnt != '0) begin
            s_d.diag_cnt = s_q.diag_cnt - 1'b1;
        end

        // Thermal flag sets at the trip point, releases below the lower point
        if (pins[sfh_pkg::PIN_TEMP_TRIP]) begin
            s_d.therm = 1'b1;
            // Pulse only on the first trip, not while the flag is held
            if (!s_q.therm) begin
                s_d.diag_cnt = DIAG_LEN;
            end
        // Release needs the die below the lower point
        end else if (!pins[sfh_pkg::PIN_TEMP_WARM]) begin
            s_d.therm = 1'b0;
        end

        unique case (s_q.state)
            // High-voltage source charging the supply
            sfh_pkg::ST_CHARGE: begin
                // Switch stays off while the source charges the supply
                s_d.gate = 1'b0;
                // Turn-on threshold reached: wake the logic unless the die is still hot
                if (pins[sfh_pkg::PIN_VDD_ON]) begin
                    // Every restart starts the confirmations afresh
                    restart = 1'b1;
                    // Three reduced-peak cycles again
                    s_d.soft_cnt = '0;
                    // Constant current until the output regulates again
                    s_d.in_reg = 1'b0;
                    s_d.ocp1_seen = 1'b0;
                    if (s_q.therm) begin
                        // Still hot: back to fault current, logic stays inactive, no cycle is started
                        s_d.state = sfh_pkg::ST_FAULT;
                        s_d.cause[sfh_pkg::CAUSE_THERM] = 1'b1;
                    end else begin
                        s_d.state = sfh_pkg::ST_SOFT;
                    end
                end
            end

            // Switching, the first cycles at reduced peak
            sfh_pkg::ST_SOFT, sfh_pkg::ST_RUN: begin
                // Regulation reached ends the start-up constant-current phase
                if (s_q.state == sfh_pkg::ST_RUN && OUTPUT_IN_REGULATION) begin
                    s_d.in_reg = 1'b1;
                end
                if (s_q.gate && pins[sfh_pkg::PIN_OCP1]) begin
                    s_d.ocp1_seen = 1'b1;
                end

                // Faults share one hiccup path, every cause present recorded together, ahead of supply collapse
                if (s_q.therm || pins[sfh_pkg::PIN_VS_OV] || pins[sfh_pkg::PIN_CLAMP]
                    || (s_q.gate && pins[sfh_pkg::PIN_OCP2])
                    || uv_if.tripped || ocp_if.tripped || ton_if.tripped) begin
                    s_d.state = sfh_pkg::ST_FAULT;
                    s_d.gate = 1'b0;
                    s_d.cause = '0;
                    s_d.cause[sfh_pkg::CAUSE_THERM] = s_q.therm;
                    s_d.cause[sfh_pkg::CAUSE_OV] = pins[sfh_pkg::PIN_VS_OV];
                    s_d.cause[sfh_pkg::CAUSE_CLAMP] = pins[sfh_pkg::PIN_CLAMP];
                    s_d.cause[sfh_pkg::CAUSE_OCP2] = s_q.gate && pins[sfh_pkg::PIN_OCP2];
                    s_d.cause[sfh_pkg::CAUSE_UV] = uv_if.tripped;
                    s_d.cause[sfh_pkg::CAUSE_OCP1] = ocp_if.tripped;
                    s_d.cause[sfh_pkg::CAUSE_TON] = ton_if.tripped;
                end else if (pins[sfh_pkg::PIN_VDD_OFF]) begin
                    // Supply collapse without fault: stop at start-up current
                    s_d.state = sfh_pkg::ST_STANDBY;
                    s_d.gate = 1'b0;
                end else if (s_q.gate) begin
                    // Timer counts only while on and the gate drops at the limit, so it cannot wrap
                    s_d.on_cnt = s_q.on_cnt + 1'b1;
                    // Cycle ends at the peak limit or at the on-time limit
                    if (pins[sfh_pkg::PIN_PEAK] || s_q.on_cnt >= ton_limit) begin
                        s_d.gate = 1'b0;
                        s_d.sample = 1'b1;
                        cycle_end = 1'b1;
                        uv_sensed = pins[sfh_pkg::PIN_VS_LOW];
                        ocp_sensed = s_d.ocp1_seen;
                        ton_sensed = !pins[sfh_pkg::PIN_PEAK];
                        // Line enable with hysteresis; between the levels the last verdict holds
                        if (pins[sfh_pkg::PIN_VS_EN]) begin
                            s_d.line_ok = 1'b1;
                        end else if (pins[sfh_pkg::PIN_VS_LOW]) begin
                            s_d.line_ok = 1'b0;
                        end
                        if (s_q.state == sfh_pkg::ST_SOFT && s_q.soft_cnt != SOFT_LAST) begin
                            s_d.soft_cnt = s_q.soft_cnt + 2'h1;
                        end
                    end
                end else if (s_q.state == sfh_pkg::ST_SOFT && s_q.soft_cnt == SOFT_LAST
                             && s_q.line_ok) begin
                    // Full peak only once three cycles passed and line is enabled
                    s_d.state = sfh_pkg::ST_RUN;
                end else if (SWITCH_REQUEST) begin
                    // New on time: limit timer and over-current memory start over
                    s_d.gate = 1'b1;
                    s_d.on_cnt = '0;
                    s_d.ocp1_seen = 1'b0;
                end
            end

            // Fault: low current, supply discharges slowly to the restart point
            sfh_pkg::ST_FAULT: begin
                // Gate held off; the cause stays readable through the hiccup
                s_d.gate = 1'b0;
                // Slow discharge keeps the source duty low under a lasting fault
                if (pins[sfh_pkg::PIN_VDD_RESTART]) begin
                    // Counters are cleared later, at turn-on
                    s_d.state = sfh_pkg::ST_CHARGE;
                end
            end

            // Supply under-voltage without fault, same return path
            sfh_pkg::ST_STANDBY: begin
                // No fault current here: the supply simply ran low
                s_d.gate = 1'b0;
                // Same return path as a fault, without a cause update
                if (pins[sfh_pkg::PIN_VDD_RESTART]) begin
                    s_d.state = sfh_pkg::ST_CHARGE;
                end
            end
        endcase
    end

    // State register
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            s_q <= RESET_STATE;
        end else begin
            s_q <= s_d;
        end
    end

    // Power stage outputs
    assign GATE_ON = s_q.gate;
    assign VS_CLAMP_ON = s_q.gate;
    assign VS_SAMPLE_STROBE = s_q.sample;
    assign REDUCED_PEAK = (s_q.state == sfh_pkg::ST_SOFT);
    assign STARTUP_CC_MODE = !s_q.in_reg;

    // Supply outputs; a shorted supply gets only the reduced charge
    assign HV_SOURCE_ON = (s_q.state == sfh_pkg::ST_CHARGE);
    assign HV_REDUCED_CHARGE = HV_SOURCE_ON && pins[sfh_pkg::PIN_VDD_1V];
    assign LOGIC_ACTIVE = (s_q.state == sfh_pkg::ST_SOFT) || (s_q.state == sfh_pkg::ST_RUN);
    assign FAULT_CURRENT_MODE = (s_q.state == sfh_pkg::ST_FAULT);

    // Diagnostics
    assign IPK_DIAG_PULSE = (s_q.diag_cnt != '0);
    // Cause of the last fault, kept until the next one
    assign FAULT_CAUSE = s_q.cause;

endmodule // sfh_fault_hiccup

// ### verification/sfh_stage_model.sv
`timescale 1ns/1ps
module sfh_stage_model (
    // Clock
    input wire logic clk,
    // Gate and knobs
    input wire logic gate,
    input wire logic [11:0] dly,
    input wire logic over1,
    input wire logic over2,
    // Drain comparators
    output logic peak = 1'b0,
    output logic oc1 = 1'b0,
    output logic oc2 = 1'b0
);
    logic [11:0] t = 12'h000; // Cycles since switch on
    // Current ramps while on, collapses at turn-off; zero dly never peaks
    always @(posedge clk) begin
        t <= gate ? t + 12'h001 : 12'h000;
        peak <= gate && dly != 12'h000 && t >= dly;
        oc1 <= gate && over1;
        oc2 <= gate && over2;
    end
endmodule // sfh_stage_model

// ### verification/sfh_fault_hiccup_props.sv
`timescale 1ns/1ps
module sfh_fault_hiccup_props (
    // Clock and reset
    input wire logic CLK,
    input wire logic RESET_N,
    // Watched inputs
    input wire logic VDD_ABOVE_TURN_ON,
    input wire logic VDD_BELOW_RESTART,
    input wire logic VS_SAMPLE_OVER,
    input wire logic TEMP_ABOVE_TRIP,
    input wire logic DRAIN_ABOVE_OCP2,
    // Watched outputs
    input wire logic GATE_ON,
    input wire logic VS_CLAMP_ON,
    input wire logic VS_SAMPLE_STROBE,
    input wire logic HV_SOURCE_ON,
    input wire logic LOGIC_ACTIVE,
    input wire logic FAULT_CURRENT_MODE,
    input wire logic IPK_DIAG_PULSE,
    input wire logic [sfh_pkg::CAUSE_W-1:0] FAULT_CAUSE
);
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RESET_N);
    logic [12:0] on_q; // Gate-high cycles so far
    logic [8:0] dg_q; // Diag pulse width so far
    // Width counters, cleared while their signal is low
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            on_q <= 13'h0;
            dg_q <= 9'h0;
        end else begin
            on_q <= GATE_ON ? on_q + 13'h1 : 13'h0;
            dg_q <= IPK_DIAG_PULSE ? dg_q + 9'h1 : 9'h0;
        end
    end
    property p_clamp; VS_CLAMP_ON == GATE_ON; endproperty
    a_clamp: assert property (p_clamp) else $error("clamp differs from gate");
    property p_strobe; VS_SAMPLE_STROBE |-> !GATE_ON && $past(GATE_ON); endproperty
    a_strobe: assert property (p_strobe) else $error("strobe without turn-off");
    property p_fgate; FAULT_CURRENT_MODE |-> !GATE_ON && !HV_SOURCE_ON; endproperty
    a_fgate: assert property (p_fgate) else $error("switching in fault");
    property p_ov; $rose(VS_SAMPLE_OVER) && LOGIC_ACTIVE |-> ##[1:6] FAULT_CAUSE[0]; endproperty
    a_ov: assert property (p_ov) else $error("over-voltage not declared");
    property p_ocp2; $rose(DRAIN_ABOVE_OCP2) && GATE_ON |-> ##[1:6] FAULT_CURRENT_MODE; endproperty
    a_ocp2: assert property (p_ocp2) else $error("second level not immediate");
    property p_therm; $rose(TEMP_ABOVE_TRIP) && LOGIC_ACTIVE |-> ##[1:6] FAULT_CAUSE[2]; endproperty
    a_therm: assert property (p_therm) else $error("thermal trip missed");
    property p_rst; $rose(VDD_BELOW_RESTART) && FAULT_CURRENT_MODE |-> ##[1:6] HV_SOURCE_ON; endproperty
    a_rst: assert property (p_rst) else $error("source not restarted");
    property p_on; $rose(VDD_ABOVE_TURN_ON) && HV_SOURCE_ON && !VDD_BELOW_RESTART |-> ##[1:6] !HV_SOURCE_ON;
    endproperty
    a_on: assert property (p_on) else $error("source left on at turn-on");
    property p_ton; on_q <= sfh_pkg::TON_MAX_CYC + 1; endproperty
    a_ton: assert property (p_ton) else $error("on time over limit");
    property p_diag; $fell(IPK_DIAG_PULSE) |-> dg_q == sfh_pkg::DIAG_PULSE_CYC; endproperty
    a_diag: assert property (p_diag) else $error("diag pulse width wrong");
endmodule // sfh_fault_hiccup_props
bind sfh_fault_hiccup sfh_fault_hiccup_props u_props (.CLK, .RESET_N, .VDD_ABOVE_TURN_ON, .VDD_BELOW_RESTART,
    .VS_SAMPLE_OVER, .TEMP_ABOVE_TRIP, .DRAIN_ABOVE_OCP2, .GATE_ON, .VS_CLAMP_ON, .VS_SAMPLE_STROBE,
    .HV_SOURCE_ON, .LOGIC_ACTIVE, .FAULT_CURRENT_MODE, .IPK_DIAG_PULSE, .FAULT_CAUSE);

// ### verification/tb_top.sv
`timescale 1ns/1ps
module tb_top;
    logic clk = 1'b0, rst_n = 1'b0;
    // Comparator levels
    logic b1v = 1'b0, von = 1'b0, voff = 1'b0, vrs = 1'b0, vov = 1'b0, vlo = 1'b0, ven = 1'b1;
    logic ttr = 1'b0, trl = 1'b0, clp = 1'b0, sw = 1'b0, reg_ok = 1'b0, o1 = 1'b0, o2 = 1'b0;
    logic [7:0] code = 8'h00;
    logic [11:0] dly = 12'h00a; // Peak reached this late
    // Outputs
    logic gate, redpk, stcc, hv, hvr, act, flt, diag, strobe, pk, oc1, oc2;
    logic [6:0] cause;
    logic [7:0] mon;
    int miscompares = 0, n_checks = 0, ton;
    assign mon = {strobe, stcc, diag, redpk, hv, flt, act, gate};
    always #2.5 clk = ~clk;
    sfh_stage_model stage (.clk(clk), .gate(gate), .dly(dly), .over1(o1), .over2(o2), .peak(pk), .oc1(oc1),
        .oc2(oc2));
    sfh_fault_hiccup DUT (.CLK(clk), .RESET_N(rst_n), .VDD_BELOW_1V(b1v), .VDD_ABOVE_TURN_ON(von),
        .VDD_BELOW_TURN_OFF(voff), .VDD_BELOW_RESTART(vrs), .VS_SAMPLE_OVER(vov), .VS_CURRENT_LOW(vlo),
        .VS_CURRENT_ENABLE(ven), .TEMP_ABOVE_TRIP(ttr), .TEMP_ABOVE_RELEASE(trl), .DRAIN_ABOVE_PEAK(pk),
        .DRAIN_ABOVE_OCP1(oc1), .DRAIN_ABOVE_OCP2(oc2), .CLAMP_OVER_CURRENT(clp), .SWITCH_REQUEST(sw),
        .PEAK_CODE(code), .OUTPUT_IN_REGULATION(reg_ok), .GATE_ON(gate), .VS_CLAMP_ON(), .VS_SAMPLE_STROBE(strobe),
        .REDUCED_PEAK(redpk), .STARTUP_CC_MODE(stcc), .HV_SOURCE_ON(hv), .HV_REDUCED_CHARGE(hvr),
        .LOGIC_ACTIVE(act), .FAULT_CURRENT_MODE(flt), .IPK_DIAG_PULSE(diag), .FAULT_CAUSE(cause));
    task conclude;
        $display("checks %0d miscompares %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task chk(input string nm, input logic [15:0] e, input logic [15:0] s);
        n_checks++;
        if (s !== e) begin
            miscompares++;
            $display("Error %s expected %h seen %h", nm, e, s);
        end
    endtask
    // Bounded wait for one monitored output
    task wt(input int b, input logic v, input int lim);
        int i;
        for (i = 0; i < lim && mon[b] !== v; i++) @(negedge clk);
        if (mon[b] !== v) begin
            miscompares++;
            $display("Error wait bit %0d expected %b seen %b", b, v, mon[b]);
            conclude();
        end
    endtask
    // One switching cycle; c forces expiry of the on-time limit
    task cyc(input logic a, input logic b, input logic c);
        o1 = a;
        vlo = b;
        ven = !b;
        dly = c ? 12'h000 : 12'h00a;
        sw = 1'b1;
        wt(0, 1'b1, 10);
        sw = 1'b0;
        ton = 0;
        while (gate === 1'b1 && ton < 5000) begin
            @(negedge clk);
            ton++;
        end
        wt(0, 1'b0, 1);
        chk("strobe", 1'b1, strobe);
        if (c) chk("on_time", 16'(1 + sfh_pkg::TON_MIN_CYC + code * 2400 / 255), ton[15:0]);
        o1 = 1'b0;
        vlo = 1'b0;
        ven = 1'b1;
        repeat (8) @(negedge clk);
    endtask
    task up;
        von = 1'b1;
        wt(1, 1'b1, 20);
        chk("hv_src", 1'b0, hv);
        chk("red_pk", 1'b1, redpk);
        chk("cc_mode", 1'b1, stcc);
    endtask
    task restart;
        {o1, o2, vov, clp, vlo, von, reg_ok} = 7'h00;
        vrs = 1'b1;
        voff = 1'b1; // Supply below both points; a running block drops to standby first
        wt(3, 1'b1, 20);
        chk("fault_mode", 1'b0, flt);
        vrs = 1'b0;
        voff = 1'b0;
        repeat (6) @(negedge clk);
    endtask
    task run;
        up();
        repeat (2) cyc(1'b0, 1'b0, 1'b0);
        chk("red_pk", 1'b1, redpk);
        cyc(1'b0, 1'b0, 1'b0);
        chk("red_pk", 1'b0, redpk);
    endtask
    task fchk(input logic [6:0] cs);
        wt(2, 1'b1, 20);
        chk("gate", 1'b0, gate);
        chk("cause", cs, cause);
        restart();
    endtask
    task t_reset;
        chk("hv_src", 1'b1, hv);
        chk("cc_mode", 1'b1, stcc);
        b1v = 1'b1;
        repeat (6) @(negedge clk);
        chk("red_chg", 1'b1, hvr);
        b1v = 1'b0;
        repeat (6) @(negedge clk);
        chk("red_chg", 1'b0, hvr);
        $display("t_reset done");
    endtask
    task t_start;
        run();
        chk("cc_mode", 1'b1, stcc);
        reg_ok = 1'b1;
        wt(6, 1'b0, 10);
        code = 8'hff;
        cyc(1'b0, 1'b0, 1'b1);
        code = 8'h00;
        restart();
        $display("t_start done");
    endtask
    // Counts confirm on the third cycle only; a clean cycle clears them
    task t_cons(input logic a, input logic b, input logic c, input logic [6:0] cs);
        run();
        repeat (2) cyc(a, b, c);
        cyc(1'b0, 1'b0, 1'b0);
        repeat (2) cyc(a, b, c);
        chk("early_fault", 1'b0, flt);
        cyc(a, b, c);
        fchk(cs);
        $display("t_cons %h done", cs);
    endtask
    task t_imm(input int k);
        run();
        sw = 1'b1;
        wt(0, 1'b1, 10);
        sw = 1'b0;
        case (k)
            0: vov = 1'b1;
            4: o2 = 1'b1;
            default: clp = 1'b1;
        endcase
        fchk(7'(1 << k));
        $display("t_imm %0d done", k);
    endtask
    task t_therm;
        run();
        {ttr, trl} = 2'h3;
        wt(2, 1'b1, 20);
        chk("cause", 7'h04, cause);
        wt(5, 1'b1, 20);
        wt(5, 1'b0, 300);
        ttr = 1'b0;
        restart();
        von = 1'b1;
        wt(3, 1'b0, 20);
        chk("fault_mode", 1'b1, flt);
        chk("logic", 1'b0, act);
        trl = 1'b0;
        restart();
        run();
        restart();
        $display("t_therm done");
    endtask
    initial begin
        repeat (20) @(negedge clk);
        rst_n = 1'b1;
        repeat (2) @(negedge clk);
        t_reset();
        t_start();
        t_cons(1'b1, 1'b0, 1'b0, 7'h08);
        t_cons(1'b0, 1'b1, 1'b0, 7'h02);
        t_cons(1'b0, 1'b0, 1'b1, 7'h20);
        t_imm(0);
        t_imm(4);
        t_imm(6);
        t_therm();
        conclude();
    end
endmodule // tb_top
